// >>> fbeh_core.v
// fbeh_core.v - emergency message builder, error state handling,
// output substitution, pwm outputs and run/error indicators.
// assumes all condition inputs come from logic on clk, except the
// restore-defaults switch, which is a pin and is synchronised here.
//
// Behaviour
// - send 8-byte emergency on detected error
// - each distinct error sent once while it stays active
// - all causes cleared: send zero message
// - code bytes 0-1 lsb first, byte2 register
// - reset causes coded 5000h, 6100h, 6101h
// - lost 8110h, passive 8120h, busoff 8140h
// - guard/heartbeat 8130h, node id in byte3
// - pdo length 8210h, stack overrun 6102h
// - error register bytes 81h, 11h, 01h, 00h
// - run indicator on, blink, single flash
// - error indicator off, single, double, on
// - joint triple, alternate, fast blink patterns
// - error behaviour: preop, keep, stopped
// - stack overrun forces outputs until reset
// - outputs changed only with state change; code substitutes on each new error unless keep, and always on stack overrun
// - digital outputs take error value per mode
// - pwm duty takes error value per mode
// - outputs hold until rewritten; start needs clear
// - duty unsigned 16-bit, linear, default zero
// - period in microseconds, default 1000
`include "fbeh_regs.vh"
module fbeh_core #(
   parameter PWM_CH = 2,
   parameter FLICK_CYC = `FBEH_FLICK_US * `FBEH_CLK_MHZ
) (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // register port
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   // error conditions, levels, one per cause
   input wire [8:0] err_cond,
   input wire [7:0] hb_fail_node,
   input wire can_warn,
   input wire lss_active,
   input wire restore_sw,
   // nmt commands, one-cycle pulses
   input wire nmt_start,
   input wire nmt_preop,
   input wire nmt_stop,
   // emergency message out
   output reg emcy_valid,
   output reg [63:0] emcy_data,
   input wire emcy_ready,
   // outputs
   output reg [7:0] digital_outputs,
   output wire digital_output_zero,
   output wire digital_output_one,
   output wire [PWM_CH-1:0] pwm_out,
   output reg [1:0] nmt_state,
   output reg run_indicator,
   output reg error_indicator
);
////////////////////////////////////////////////////////////////////////
// nmt states and error cause indices
localparam ST_PREOP = 2'h0;
localparam ST_OPER = 2'h1;
localparam ST_STOP = 2'h2;
localparam E_STACK = 3;
localparam E_GUARD = 6;
localparam E_BUSOFF = 7;
localparam US_CYC = `FBEH_PWM_UNIT_US * `FBEH_CLK_MHZ;
////////////////////////////////////////////////////////////////////////
// software-written configuration
reg [1:0] behav_q; // error behaviour
reg [7:0] do_mode_q; // digital error mode bits
reg [7:0] do_eval_q; // digital error values
reg [PWM_CH-1:0] pwm_mode_q; // pwm error mode bits
reg [15:0] duty_q [0:PWM_CH-1]; // duty cycles
reg [15:0] per_q [0:PWM_CH-1]; // periods in microseconds
reg [15:0] peval_q [0:PWM_CH-1]; // pwm error duty
// error tracking
reg [8:0] sent_q; // causes already reported
reg any_q; // some error reported, zero not yet sent
reg crit_q; // stack overrun latched till reset
reg [2:0] idx; // lowest pending cause
reg [15:0] code; // its error code
reg [7:0] ereg; // its error register byte
wire [8:0] pend = err_cond & ~sent_q;
wire launch_err = |pend && !emcy_valid;
wire launch_zero = !(|err_cond) && any_q && !emcy_valid;
// behaviour 1 substitutes only on stack overrun; stack overrun always does
wire subst = (launch_err && behav_q != `FBEH_BH_KEEP) || err_cond[E_STACK];
// switch synchroniser
reg sw_s1_q;
reg sw_s2_q;
integer i;
////////////////////////////////////////////////////////////////////////
// pick the lowest-numbered pending cause and encode it
always @* begin
   idx = 3'h0;
   for (i = 8; i >= 0; i = i - 1) begin
      if (pend[i]) begin
         idx = i[2:0];
      end
   end
   case (idx)
      3'h0: code = `FBEH_EC_HWRST;
      3'h1: code = `FBEH_EC_SWRST;
      3'h2: code = `FBEH_EC_WDOG;
      3'h3: code = `FBEH_EC_STACK;
      3'h4: code = `FBEH_EC_LOST;
      3'h5: code = `FBEH_EC_PASSIVE;
      3'h6: code = `FBEH_EC_GUARD;
      3'h7: code = `FBEH_EC_BUSOFF;
      default: code = `FBEH_EC_PDOLEN;
   endcase
   if (pend == 9'h100) begin
      code = `FBEH_EC_PDOLEN;
   end
   if (code == `FBEH_EC_STACK) begin
      ereg = `FBEH_ER_MFR;
   end else if (code[15]) begin
      ereg = `FBEH_ER_COMM;
   end else begin
      ereg = `FBEH_ER_GEN;
   end
end
////////////////////////////////////////////////////////////////////////
// emergency producer: one message per new cause, zero when all clear
always @(posedge clk) begin
   if (sys_rst) begin
      emcy_valid <= 1'b0;
      emcy_data <= 64'h0;
      sent_q <= 9'h0;
      any_q <= 1'b0;
   end else begin
      // a cleared cause may be reported again if it comes back
      sent_q <= sent_q & err_cond;
      if (emcy_valid && emcy_ready) begin
         emcy_valid <= 1'b0;
      end
      if (launch_err) begin
         emcy_valid <= 1'b1;
         emcy_data <= {32'h0, (code == `FBEH_EC_GUARD) ? hb_fail_node : 8'h00, ereg, code[15:8], code[7:0]};
         sent_q <= (sent_q & err_cond) | (pend & ~(pend - 9'h1));
         any_q <= 1'b1;
      end else if (launch_zero) begin
         emcy_valid <= 1'b1;
         emcy_data <= 64'h0;
         any_q <= 1'b0;
      end
   end
end
////////////////////////////////////////////////////////////////////////
// nmt state and critical latch
always @(posedge clk) begin
   if (sys_rst) begin
      nmt_state <= ST_PREOP;
      crit_q <= 1'b0;
   end else begin
      if (err_cond[E_STACK]) begin
         crit_q <= 1'b1;
      end
      if (launch_err) begin
         case (behav_q)
            `FBEH_BH_PREOP: nmt_state <= ST_PREOP;
            `FBEH_BH_STOP: nmt_state <= ST_STOP;
            default: nmt_state <= nmt_state;
         endcase
      end else if (nmt_start && !(|err_cond) && !crit_q) begin
         nmt_state <= ST_OPER;
      end else if (nmt_preop) begin
         nmt_state <= ST_PREOP;
      end else if (nmt_stop) begin
         nmt_state <= ST_STOP;
      end
   end
end
////////////////////////////////////////////////////////////////////////
// configuration and output value registers
always @(posedge clk) begin
   if (sys_rst) begin
      behav_q <= `FBEH_BEHAV_RST;
      do_mode_q <= 8'h00;
      do_eval_q <= 8'h00;
      pwm_mode_q <= {PWM_CH{1'b0}};
      digital_outputs <= 8'h00;
   end else begin
      if (reg_wr && reg_addr == `FBEH_REG_BEHAV) begin
         behav_q <= reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == `FBEH_REG_DO_MODE) begin
         do_mode_q <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == `FBEH_REG_DO_EVAL) begin
         do_eval_q <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == `FBEH_REG_PWM_MODE) begin
         pwm_mode_q <= reg_wdata[PWM_CH-1:0];
      end
      if (subst) begin
         digital_outputs <= (digital_outputs & ~do_mode_q) | (do_eval_q & do_mode_q);
      end else if (reg_wr && reg_addr == `FBEH_REG_DO_VAL && !crit_q) begin
         digital_outputs <= reg_wdata[7:0];
      end
   end
end
assign digital_output_zero = digital_outputs[0];
assign digital_output_one = digital_outputs[1];
////////////////////////////////////////////////////////////////////////
// microsecond prescaler shared by all pwm channels
reg [7:0] us_cnt_q;
wire us_tick = (us_cnt_q == US_CYC - 1);
always @(posedge clk) begin
   if (sys_rst || us_tick) begin
      us_cnt_q <= 8'h00;
   end else begin
      us_cnt_q <= us_cnt_q + 8'h01;
   end
end
////////////////////////////////////////////////////////////////////////
// pwm channels
genvar g;
generate
   for (g = 0; g < PWM_CH; g = g + 1) begin : g_pwm
      reg [15:0] cnt_q; // microsecond count within period
      reg out_q;
      wire [31:0] prod = duty_q[g] * per_q[g];
      always @(posedge clk) begin
         if (sys_rst) begin
            duty_q[g] <= `FBEH_DUTY_RST;
            per_q[g] <= `FBEH_PER_RST;
            peval_q[g] <= 16'h0000;
            cnt_q <= 16'h0000;
            out_q <= 1'b0;
         end else begin
            if (subst && pwm_mode_q[g]) begin
               duty_q[g] <= peval_q[g];
            end else if (reg_wr && reg_addr == `FBEH_REG_DUTY0 + g && !crit_q) begin
               duty_q[g] <= reg_wdata;
            end
            // short periods are the master's fault
            if (reg_wr && reg_addr == `FBEH_REG_PER0 + g) begin
               per_q[g] <= reg_wdata;
            end
            if (reg_wr && reg_addr == `FBEH_REG_PEVAL0 + g) begin
               peval_q[g] <= reg_wdata;
            end
            if (us_tick) begin
               cnt_q <= (cnt_q + 16'h1 >= per_q[g]) ? 16'h0000 : cnt_q + 16'h1;
            end
            // linear scaling, ffff is full on
            out_q <= (duty_q[g] == 16'hffff) || (cnt_q < prod[31:16]);
         end
      end
      assign pwm_out[g] = out_q;
   end
endgenerate
////////////////////////////////////////////////////////////////////////
// register reads, data one cycle after the strobe
always @(posedge clk) begin
   if (sys_rst) begin
      reg_rdata <= 16'h0000;
   end else if (reg_rd) begin
      case (reg_addr)
         `FBEH_REG_BEHAV: reg_rdata <= {14'h0, behav_q};
         `FBEH_REG_DO_MODE: reg_rdata <= {8'h0, do_mode_q};
         `FBEH_REG_DO_EVAL: reg_rdata <= {8'h0, do_eval_q};
         `FBEH_REG_PWM_MODE: reg_rdata <= {{(16-PWM_CH){1'b0}}, pwm_mode_q};
         `FBEH_REG_STATUS: reg_rdata <= {3'h0, crit_q, any_q, err_cond, nmt_state};
         `FBEH_REG_DO_VAL: reg_rdata <= {8'h0, digital_outputs};
         `FBEH_REG_DUTY0: reg_rdata <= duty_q[0];
         `FBEH_REG_DUTY0 + 4'h1: reg_rdata <= duty_q[PWM_CH-1];
         `FBEH_REG_PER0: reg_rdata <= per_q[0];
         `FBEH_REG_PER0 + 4'h1: reg_rdata <= per_q[PWM_CH-1];
         `FBEH_REG_PEVAL0: reg_rdata <= peval_q[0];
         `FBEH_REG_PEVAL0 + 4'h1: reg_rdata <= peval_q[PWM_CH-1];
         // unmapped reads return zero
         default: reg_rdata <= 16'h0000;
      endcase
   end
end
////////////////////////////////////////////////////////////////////////
// indicator timebase: flicker tick, blink half period, flash steps
reg [31:0] fl_cnt_q;
reg flick_q; // fast blink phase
reg [1:0] bl_cnt_q;
reg blink_q; // 50:50 blink phase
reg [3:0] step_q; // flash frame position
wire fl_tick = (fl_cnt_q == FLICK_CYC - 1);
wire bl_tick = fl_tick && (bl_cnt_q == `FBEH_BLINK_FLICKS - 1);
always @(posedge clk) begin
   if (sys_rst) begin
      fl_cnt_q <= 32'h0;
      flick_q <= 1'b0;
      bl_cnt_q <= 2'h0;
      blink_q <= 1'b0;
      step_q <= 4'h0;
      sw_s1_q <= 1'b0;
      sw_s2_q <= 1'b0;
   end else begin
      sw_s1_q <= restore_sw;
      sw_s2_q <= sw_s1_q;
      fl_cnt_q <= fl_tick ? 32'h0 : fl_cnt_q + 32'h1;
      if (fl_tick) begin
         flick_q <= ~flick_q;
         bl_cnt_q <= bl_cnt_q + 2'h1;
      end
      if (bl_tick) begin
         blink_q <= ~blink_q;
         step_q <= (step_q == `FBEH_FLASH_STEPS - 1) ? 4'h0 : step_q + 4'h1;
      end
   end
end
////////////////////////////////////////////////////////////////////////
// indicator pattern selection, joint patterns take precedence
wire fl1 = (step_q == 4'h0);
wire fl2 = fl1 || (step_q == 4'h2);
wire fl3 = fl2 || (step_q == 4'h4);
always @(posedge clk) begin
   if (sys_rst) begin
      run_indicator <= 1'b0;
      error_indicator <= 1'b0;
   end else if (sw_s2_q) begin
      run_indicator <= flick_q;
      error_indicator <= flick_q;
   end else if (lss_active) begin
      run_indicator <= blink_q;
      error_indicator <= ~blink_q;
   end else if (crit_q) begin
      run_indicator <= fl3;
      error_indicator <= fl3;
   end else begin
      case (nmt_state)
         ST_OPER: run_indicator <= 1'b1;
         ST_STOP: run_indicator <= fl1;
         default: run_indicator <= blink_q;
      endcase
      if (err_cond[E_BUSOFF]) begin
         error_indicator <= 1'b1;
      end else if (err_cond[E_GUARD]) begin
         error_indicator <= fl2;
      end else if (can_warn) begin
         error_indicator <= fl1;
      end else begin
         error_indicator <= 1'b0;
      end
   end
end
endmodule // fbeh_core

// >>> fbeh_core_chk.sv
// fbeh_core_chk.sv - timing checks on the error handler ports.
// assumes one clock domain and a synchronous active-high reset.
module fbeh_core_chk (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // causes and commands
   input wire [8:0] err_cond,
   input wire lss_active,
   input wire restore_sw,
   input wire nmt_start,
   input wire nmt_stop,
   // emergency link
   input wire emcy_valid,
   input wire [63:0] emcy_data,
   input wire emcy_ready,
   // state and indicators
   input wire [1:0] nmt_state,
   input wire run_indicator,
   input wire error_indicator
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_EMCY_HOLD: assert property (emcy_valid && !emcy_ready |=> emcy_valid && $stable(emcy_data))
      else $error("emergency changed before taken");
   AST_BUSOFF_SENT: assert property ($rose(err_cond[7]) |-> ##[1:60] emcy_valid && emcy_data[23:0] == 24'h118140)
      else $error("bus-off message missing");
   AST_ZERO_MSG: assert property (emcy_valid && emcy_data[15:0] == 16'h0 |-> emcy_data == 64'h0)
      else $error("clear message not all zero");
   AST_STACK_REG: assert property (emcy_valid && emcy_data[15:0] == 16'h6102 |-> emcy_data[23:16] == 8'h81)
      else $error("stack overrun register byte wrong");
   AST_TAIL_ZERO: assert property (emcy_valid && emcy_data[15:0] != 16'h8130 |-> emcy_data[63:24] == 40'h0)
      else $error("detail bytes not zero");
   AST_START_GATE: assert property (nmt_start && err_cond != 9'h0 && nmt_state != 2'h1 |=> nmt_state != 2'h1)
      else $error("start taken with error active");
   AST_STOP_CMD: assert property (nmt_stop && !nmt_start && err_cond == 9'h0 |=> nmt_state == 2'h2)
      else $error("stop command ignored");
   AST_BUSOFF_LED: assert property ((err_cond[7] && !err_cond[3] && !lss_active && !restore_sw) [*4] |-> error_indicator)
      else $error("error indicator not steady at bus-off");
   AST_RUN_ON: assert property ((nmt_state == 2'h1 && err_cond == 9'h0 && !lss_active && !restore_sw) [*4] |-> run_indicator)
      else $error("run indicator not steady when operational");
endmodule // fbeh_core_chk
bind fbeh_core fbeh_core_chk chk_u (.clk(clk), .sys_rst(sys_rst), .err_cond(err_cond), .lss_active(lss_active),
   .restore_sw(restore_sw), .nmt_start(nmt_start), .nmt_stop(nmt_stop), .emcy_valid(emcy_valid),
   .emcy_data(emcy_data), .emcy_ready(emcy_ready), .nmt_state(nmt_state), .run_indicator(run_indicator),
   .error_indicator(error_indicator));

// >>> fbeh_emcy_sink.sv
// fbeh_emcy_sink.sv - model of the network side taking emergency messages.
// assumes the emergency handshake runs on clk; stall sets the answer delay.
module fbeh_emcy_sink (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // emergency link
   input wire emcy_valid,
   input wire [63:0] emcy_data,
   output logic emcy_ready,
   // answer delay in cycles
   input wire [3:0] stall
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [63:0] got_q[$]; // messages taken, oldest first
   int wait_cnt; // cycles waited on this message
   always @(posedge clk) begin
      if (sys_rst) begin
         emcy_ready <= 1'b0;
         wait_cnt <= 0;
      end else if (emcy_valid && emcy_ready) begin
         got_q.push_back(emcy_data);
         emcy_ready <= 1'b0;
         wait_cnt <= 0;
      end else if (emcy_valid && wait_cnt >= stall) begin
         emcy_ready <= 1'b1;
      end else if (emcy_valid) begin
         wait_cnt <= wait_cnt + 1;
      end
   end
endmodule // fbeh_emcy_sink

// >>> fbeh_regs.vh
// fbeh_regs.vh - register indices, field codes and timing constants
// of the fieldbus error and output handler.
// assumes a word-indexed register port with 16-bit data.
`ifndef FBEH_REGS_VH
`define FBEH_REGS_VH
////////////////////////////////////////////////////////////////////////
// register indices
`define FBEH_REG_BEHAV 4'h0
`define FBEH_REG_DO_MODE 4'h1
`define FBEH_REG_DO_EVAL 4'h2
`define FBEH_REG_PWM_MODE 4'h3
`define FBEH_REG_STATUS 4'h4
`define FBEH_REG_DO_VAL 4'h5
`define FBEH_REG_DUTY0 4'h8
`define FBEH_REG_PER0 4'ha
`define FBEH_REG_PEVAL0 4'hc
////////////////////////////////////////////////////////////////////////
// reset values
`define FBEH_PER_RST 16'h03e8
`define FBEH_DUTY_RST 16'h0000
`define FBEH_BEHAV_RST 2'h0
////////////////////////////////////////////////////////////////////////
// emergency error codes
`define FBEH_EC_HWRST 16'h5000
`define FBEH_EC_SWRST 16'h6100
`define FBEH_EC_WDOG 16'h6101
`define FBEH_EC_STACK 16'h6102
`define FBEH_EC_LOST 16'h8110
`define FBEH_EC_PASSIVE 16'h8120
`define FBEH_EC_GUARD 16'h8130
`define FBEH_EC_BUSOFF 16'h8140
`define FBEH_EC_PDOLEN 16'h8210
// error register byte values
`define FBEH_ER_MFR 8'h81
`define FBEH_ER_COMM 8'h11
`define FBEH_ER_GEN 8'h01
// error behaviour values
`define FBEH_BH_PREOP 2'h0
`define FBEH_BH_KEEP 2'h1
`define FBEH_BH_STOP 2'h2
////////////////////////////////////////////////////////////////////////
// timing: clock rate, pwm unit, indicator flicker step
`define FBEH_CLK_MHZ 50
`define FBEH_PWM_UNIT_US 1
`define FBEH_FLICK_US 50000
`define FBEH_BLINK_FLICKS 4
`define FBEH_FLASH_STEPS 10
`endif

// >>> testbench.sv
// testbench.sv - self-checking bench of the error and output handler.
// assumes fbeh_core, its register header and the sink model are compiled first.
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: mismatch", $time); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [8:0] err_cond = 9'h0;
   logic [7:0] hb_node = 8'h0;
   logic [2:0] cmd = 3'h0; // start, preop, stop
   logic [3:0] stall = 4'h0;
   wire [15:0] reg_rdata;
   wire emcy_valid;
   wire emcy_ready;
   wire [63:0] emcy_data;
   wire [7:0] dout;
   wire [1:0] state;
   // indicator timebase of this bench: flick, blink half period, flash frame
   localparam int FL = 20;
   localparam int BL = FL * 4;
   localparam int FR = BL * 10;
   logic warn = 1'b0; // can warning level
   logic lss = 1'b0; // layer-setting service running
   logic sw = 1'b0; // restore-defaults switch pin
   wire out_zero;
   wire out_one;
   wire run_led;
   wire err_led;
   wire [1:0] pwm;
   int run_n; // run indicator on-cycles in a window
   int err_n; // error indicator on-cycles in a window
   int same_n; // cycles where both indicators agree
   int pw_n; // pwm high cycles in one period
   logic [31:0] lfsr_s = 32'h1c62;
   logic [15:0] dval;
   logic [15:0] duty;
   logic [63:0] exp_q[$]; // expected messages
   int errors = 0;
   int check_count = 0;
   int cyc = 0;
   int beh;
   fbeh_core #(.PWM_CH(2), .FLICK_CYC(FL)) dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_cond(err_cond),
      .hb_fail_node(hb_node), .can_warn(warn), .lss_active(lss), .restore_sw(sw), .nmt_start(cmd[0]),
      .nmt_preop(cmd[1]), .nmt_stop(cmd[2]), .emcy_valid(emcy_valid), .emcy_data(emcy_data),
      .emcy_ready(emcy_ready), .digital_outputs(dout), .digital_output_zero(out_zero),
      .digital_output_one(out_one), .pwm_out(pwm), .nmt_state(state), .run_indicator(run_led),
      .error_indicator(err_led));
   fbeh_emcy_sink sink_u (.clk(clk), .sys_rst(sys_rst), .emcy_valid(emcy_valid), .emcy_data(emcy_data),
      .emcy_ready(emcy_ready), .stall(stall));
   initial begin
      forever #10 clk = ~clk;
   end
   // cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic logic [31:0] lfsr_nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // count indicator on-cycles over a window; a whole frame makes the count phase-free
   task automatic leds(input int n);
      run_n = 0;
      err_n = 0;
      same_n = 0;
      repeat (4) @(posedge clk);
      repeat (n) begin
         @(posedge clk);
         #1;
         run_n += (run_led === 1'b1);
         err_n += (err_led === 1'b1);
         same_n += (run_led === err_led);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask
   task automatic nmt(input logic [2:0] c);
      @(posedge clk);
      cmd <= c;
      @(posedge clk);
      cmd <= 3'h0;
      #1;
   endtask
   // expected message of one cause
   function automatic logic [63:0] msg(input int i, input logic [7:0] node);
      logic [15:0] c[9] = '{16'h5000, 16'h6100, 16'h6101, 16'h6102, 16'h8110, 16'h8120, 16'h8130, 16'h8140, 16'h8210};
      logic [7:0] r;
      r = (i == 3) ? 8'h81 : (c[i][15:12] == 4'h8) ? 8'h11 : 8'h01;
      return {32'h0, (i == 6) ? node : 8'h0, r, c[i]};
   endfunction
   // wait for the expected count, then make sure nothing more comes
   task automatic msgs_chk();
      for (int k = 0; k < 80 && sink_u.got_q.size() < exp_q.size(); k++) @(posedge clk);
      repeat (10) @(posedge clk);
      `CHK(sink_u.got_q.size(), exp_q.size())
      foreach (exp_q[i]) if (i < sink_u.got_q.size()) `CHK(sink_u.got_q[i], exp_q[i])
      exp_q.delete();
      sink_u.got_q.delete();
   endtask
   task automatic rst_chk();
      sys_rst <= 1'b1;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rd_chk(4'ha, 16'h03e8);
      rd_chk(4'h8, 16'h0000);
      rd_chk(4'hf, 16'h0000);
      `CHK(state, 2'h0)
   endtask
   initial begin
      rst_chk();
      wr(4'h1, 16'h0003);
      wr(4'h2, 16'h0001);
      wr(4'h3, 16'h0001);
      wr(4'hc, 16'h4000);
      // quarter duty on channel 1 over a short legal period of 44 us
      wr(4'hb, 16'h002c);
      wr(4'h9, 16'h4000);
      repeat (2200) @(posedge clk);
      pw_n = 0;
      repeat (2200) begin
         @(posedge clk);
         #1;
         pw_n += (pwm[1] === 1'b1);
      end
      `CHK(pw_n, 2200 / 4)
      // every cause except stack overrun, each with behaviour value i % 3
      for (int i = 0; i < 9; i++) begin
         if (i == 3) continue;
         beh = i % 3;
         stall <= i[3:0];
         warn <= (i == 4);
         lfsr_s = lfsr_nx(lfsr_s);
         dval = lfsr_s[15:0];
         duty = lfsr_s[31:16];
         hb_node <= lfsr_s[23:16];
         wr(4'h0, beh[15:0]);
         wr(4'h5, dval);
         wr(4'h8, duty);
         nmt(3'h1);
         @(posedge clk);
         err_cond[i] <= 1'b1;
         exp_q.push_back(msg(i, lfsr_s[23:16]));
         msgs_chk();
         `CHK(state, (beh == 0) ? 2'h0 : (beh == 1) ? 2'h1 : 2'h2)
         `CHK(dout, (beh == 1) ? dval[7:0] : ((dval[7:0] & 8'hfc) | 8'h01))
         `CHK({out_one, out_zero}, (beh == 1) ? dval[1:0] : 2'h1)
         leds(FR);
         `CHK(run_n, (beh == 0) ? FR / 2 : (beh == 1) ? FR : BL)
         `CHK(err_n, (i == 7) ? FR : (i == 6) ? 2 * BL : (i == 4) ? BL : 0)
         rd_chk(4'h8, (beh == 1) ? duty : 16'h4000);
         nmt(3'h1);
         `CHK(state, (beh == 0) ? 2'h0 : (beh == 1) ? 2'h1 : 2'h2)
         @(posedge clk);
         err_cond[i] <= 1'b0;
         exp_q.push_back(64'h0);
         msgs_chk();
      end
      // two causes at once against a slow consumer, then commands
      stall <= 4'h6;
      @(posedge clk);
      err_cond <= 9'h090;
      exp_q = '{msg(4, 8'h0), msg(7, 8'h0)};
      msgs_chk();
      err_cond <= 9'h0;
      exp_q.push_back(64'h0);
      msgs_chk();
      nmt(3'h1);
      `CHK(state, 2'h1)
      leds(40);
      `CHK(run_n, 40)
      nmt(3'h4);
      `CHK(state, 2'h2)
      nmt(3'h2);
      `CHK(state, 2'h0)
      // layer-setting service, then restore switch
      lss <= 1'b1;
      leds(2 * BL);
      `CHK(run_n, BL)
      `CHK(same_n, 0)
      lss <= 1'b0;
      sw <= 1'b1;
      leds(2 * FL);
      `CHK(err_n, FL)
      `CHK(same_n, 2 * FL)
      sw <= 1'b0;
      // stack overrun is left only by reset
      wr(4'h0, 16'h0000);
      wr(4'h5, 16'h00f0);
      nmt(3'h1);
      @(posedge clk);
      err_cond[3] <= 1'b1;
      exp_q.push_back(msg(3, 8'h0));
      msgs_chk();
      wr(4'h5, 16'h00ff);
      #1;
      `CHK(dout, 8'hf1)
      leds(FR);
      `CHK(run_n, 3 * BL)
      `CHK(same_n, FR)
      err_cond[3] <= 1'b0;
      exp_q.push_back(64'h0);
      msgs_chk();
      nmt(3'h1);
      `CHK(state, 2'h0)
      rst_chk();
      `CHK(dout, 8'h00)
      report_and_stop();
   end
endmodule // testbench
